// >>> mcs_cfg.svh
/*
  Constants for the multichannel shadow control block: register offsets,
  field positions, reset values and codes.
  Assumes inclusion by bare name from every file that needs it.
*/
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH

`define MCS_ADDR_W 8
`define MCS_OFS_SWCTRL 8'h54
`define MCS_OFS_PATTERN 8'h58
`define MCS_OFS_ENABLE 8'h5c
`define MCS_SWCTRL_RESET 16'h0000
`define MCS_SWCTRL_WMASK 16'h0737
`define MCS_TRG_LSB 0
`define MCS_TRG_MSB 2
`define MCS_SYN_LSB 4
`define MCS_SYN_MSB 5
`define MCS_BIT_MAIN_UP 8
`define MCS_BIT_MAIN_DN 9
`define MCS_BIT_AUX_UP 10
`define MCS_PAT_W 6
`define MCS_PAT_RESET 6'h00
`define MCS_PAT_ACT_LSB 8
`define MCS_PAT_PEND_BIT 16
`define MCS_RESP_OKAY 2'h0
`define MCS_RESP_SLVERR 2'h2

`endif

// >>> mcs_pkg.sv
/*
  Types for the multichannel shadow control block.
  Assumes mcs_cfg.svh is on the include path.
*/
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_TRG_NONE = 3'h0,
    MCS_TRG_HALL = 3'h1,
    MCS_TRG_AUX_PM = 3'h2,
    MCS_TRG_MAIN_OM = 3'h3,
    MCS_TRG_MAIN_CM1 = 3'h4,
    MCS_TRG_MAIN_PM = 3'h5
  } mcs_trig_t;
  typedef enum logic [1:0] {
    MCS_SYN_DIRECT = 2'h0,
    MCS_SYN_AUX_ZM = 2'h1,
    MCS_SYN_MAIN_ZM = 2'h2,
    MCS_SYN_NONE = 2'h3
  } mcs_sync_t;
  typedef enum {MCS_WR_IDLE, MCS_WR_RESP} mcs_wr_state_t;
endpackage : mcs_pkg

// >>> mcs_evt_if.sv
/*
  Interface carrying timer and hall events between the control core and
  the event selector.
  Assumes one clock domain; all signals are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
interface mcs_evt_if;
  logic hallCorrect;
  logic auxPeriodUp;
  logic mainOneDown;
  logic mainCompare1;
  logic mainPeriodUp;
  logic auxZero;
  logic mainZeroUp;
  logic trigHit;
  logic syncHit;
  modport source (output hallCorrect, auxPeriodUp, mainOneDown,
    mainCompare1, mainPeriodUp, auxZero, mainZeroUp, input trigHit, syncHit);
  modport select (input hallCorrect, auxPeriodUp, mainOneDown,
    mainCompare1, mainPeriodUp, auxZero, mainZeroUp, output trigHit, syncHit);
endinterface : mcs_evt_if
`default_nettype wire

// >>> mcs_event_sel.sv
/*
  Event selector: picks the trigger and synchronisation events from the
  selection codes.
  Assumes event pulses are synchronous to the shared clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcs_cfg.svh"
module mcs_event_sel (
  // Selection codes
  input wire logic [2:0] trigSel,
  input wire logic [1:0] syncSel,
  // Events
  mcs_evt_if.select evt
);
  import mcs_pkg::*;

  always_comb
  begin
    case (mcs_trig_t'(trigSel))
      MCS_TRG_NONE: evt.trigHit = 1'b0;
      MCS_TRG_HALL: evt.trigHit = evt.hallCorrect;
      MCS_TRG_AUX_PM: evt.trigHit = evt.auxPeriodUp;
      MCS_TRG_MAIN_OM: evt.trigHit = evt.mainOneDown;
      MCS_TRG_MAIN_CM1: evt.trigHit = evt.mainCompare1;
      MCS_TRG_MAIN_PM: evt.trigHit = evt.mainPeriodUp;
      default: evt.trigHit = 1'b0;
    endcase
  end

  always_comb
  begin
    case (mcs_sync_t'(syncSel))
      MCS_SYN_DIRECT: evt.syncHit = evt.trigHit;
      MCS_SYN_AUX_ZM: evt.syncHit = evt.auxZero;
      MCS_SYN_MAIN_ZM: evt.syncHit = evt.mainZeroUp;
      default: evt.syncHit = 1'b0;
    endcase
  end
endmodule : mcs_event_sel
`default_nettype wire

// >>> mcs_read_mux.sv
/*
  Read data selector for the register slave; read data are registered.
  Assumes the caller strobes load only when a read is accepted.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcs_cfg.svh"
module mcs_read_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request
  input wire logic load,
  input wire logic [`MCS_ADDR_W-1:0] addr,
  // Sources
  input wire logic [15:0] ctrlWord,
  input wire logic [31:0] patternWord,
  input wire logic enableBit,
  // Result
  output logic [31:0] data,
  output logic hit
);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data <= 32'h0000_0000;
      hit <= 1'b0;
    end
    else if (load)
    begin
      hit <= 1'b1;
      case (addr)
        `MCS_OFS_SWCTRL: data <= {16'h0000, ctrlWord};
        `MCS_OFS_PATTERN: data <= patternWord;
        `MCS_OFS_ENABLE: data <= {31'h0000_0000, enableBit};
        default:
        begin
          data <= 32'h0000_0000;
          hit <= 1'b0;
        end
      endcase
    end
  end
endmodule : mcs_read_mux
`default_nettype wire

// >>> mcs_shadow_ctrl.sv
/*
  Multichannel shadow control: decides when the shadow output pattern is
  copied to the active pattern, holds the pending request, launches timer
  shadow transfers, and gates PAT_W PWM outputs (six by default) with the active pattern.
  Assumes timer and hall events are one-cycle pulses on clk, and an
  AXI4-Lite master that keeps at most one read and one write under way.
*/
// Overview of operation
// - Trigger select bits 2:0 pick request event; code zero requests nothing.
// - Codes 1,2,3: hall match, aux period up, main one-match down.
// - Code 4 main compare channel 1, code 5 main period up; others none.
// - Selected trigger sets pending flag, held until the copy clears it.
// - Copy happens only on chosen sync event while pending flag is set or a request arrives.
// - Sync 0 direct, 1 aux zero, 2 main zero up, 3 nothing.
// - Reserved bits read zero; software writes zero there.
// - Bit 8 with enable: pending at main period up launches main transfer.
// - Bit 9 with enable: pending at main one-match launches main transfer.
// - Bit 10 with enable: pending at aux period launches aux transfer.
// - Copy clears pending flag; flag stays clear while enable is low.
// - With enable, active pattern zero forces output passive; one passes the PWM.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_cfg.svh"
module mcs_shadow_ctrl #(
  parameter int PAT_W = `MCS_PAT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [`MCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`MCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer and hall events
  input wire logic hallCorrect,
  input wire logic auxPeriodUp,
  input wire logic mainOneDown,
  input wire logic mainCompare1,
  input wire logic mainPeriodUp,
  input wire logic auxZero,
  input wire logic mainZeroUp,
  // PWM paths
  input wire logic [PAT_W-1:0] pwmIn,
  input wire logic [PAT_W-1:0] passiveLevel,
  output logic [PAT_W-1:0] pwmOut,
  // Timer shadow transfer launches
  output logic mainTimerShadowXfer,
  output logic auxTimerShadowXfer,
  // Status
  output logic [PAT_W-1:0] activePattern,
  output logic transferPending
);
  import mcs_pkg::*;

  initial
  begin
    if (PAT_W < 1 || PAT_W > 8)
      $error("mcs_shadow_ctrl: PAT_W must be 1 to 8");
  end

  function automatic logic [31:0] mcsMerge(input logic [31:0] oldVal,
    input logic [31:0] newVal, input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = newVal[i*8 +: 8];
    return res;
  endfunction : mcsMerge

  logic [15:0] ctrl_reg;
  logic [PAT_W-1:0] patternShadow_reg;
  logic [PAT_W-1:0] activePattern_reg;
  logic pending_reg;
  logic multichannelEnable_reg;
  logic mainXfer_reg;
  logic auxXfer_reg;
  logic [PAT_W-1:0] pwmOut_reg;
  logic [PAT_W-1:0] pwmOut_next;

  mcs_evt_if evt ();
  assign evt.hallCorrect = hallCorrect;
  assign evt.auxPeriodUp = auxPeriodUp;
  assign evt.mainOneDown = mainOneDown;
  assign evt.mainCompare1 = mainCompare1;
  assign evt.mainPeriodUp = mainPeriodUp;
  assign evt.auxZero = auxZero;
  assign evt.mainZeroUp = mainZeroUp;

  mcs_event_sel u_sel (
    .trigSel(ctrl_reg[`MCS_TRG_MSB:`MCS_TRG_LSB]),
    .syncSel(ctrl_reg[`MCS_SYN_MSB:`MCS_SYN_LSB]),
    .evt(evt.select)
  );

  // Pending as seen this cycle, including a request arriving now
  logic pendingNow;
  logic copyNow;
  assign pendingNow = multichannelEnable_reg
    && (pending_reg || evt.trigHit);
  assign copyNow = pendingNow && evt.syncHit;

  // Write channel: address and data taken in either order
  mcs_wr_state_t wrState;
  logic awHeld;
  logic wHeld;
  logic [`MCS_ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic wrFire;
  logic wrHit;

  assign s_axi_awready = (wrState == MCS_WR_IDLE) && !awHeld;
  assign s_axi_wready = (wrState == MCS_WR_IDLE) && !wHeld;
  assign wrFire = (wrState == MCS_WR_IDLE) && awHeld && wHeld;
  assign wrHit = (awAddr_reg == `MCS_OFS_SWCTRL)
    || (awAddr_reg == `MCS_OFS_PATTERN)
    || (awAddr_reg == `MCS_OFS_ENABLE);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHeld <= 1'b0;
      awAddr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end
    else if (wrFire)
      awHeld <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wHeld <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end
    else if (wrFire)
      wHeld <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrState <= MCS_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCS_RESP_OKAY;
    end
    else
    begin
      case (wrState)
        MCS_WR_IDLE:
          if (wrFire)
          begin
            wrState <= MCS_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `MCS_RESP_OKAY : `MCS_RESP_SLVERR;
          end
        MCS_WR_RESP:
          if (s_axi_bready)
          begin
            wrState <= MCS_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        default: wrState <= MCS_WR_IDLE;
      endcase
    end
  end

  // Register writes; reserved bits are never stored, so they read zero
  logic [31:0] ctrlMerged;
  logic [31:0] patMerged;
  logic [31:0] enMerged;
  assign ctrlMerged = mcsMerge({16'h0000, ctrl_reg}, wData_reg, wStrb_reg);
  assign patMerged = mcsMerge({{(32-PAT_W){1'b0}}, patternShadow_reg},
    wData_reg, wStrb_reg);
  assign enMerged = mcsMerge({31'h0000_0000, multichannelEnable_reg},
    wData_reg, wStrb_reg);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= `MCS_SWCTRL_RESET;
    else if (wrFire && awAddr_reg == `MCS_OFS_SWCTRL)
      ctrl_reg <= ctrlMerged[15:0] & `MCS_SWCTRL_WMASK;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      patternShadow_reg <= PAT_W'(`MCS_PAT_RESET);
    else if (wrFire && awAddr_reg == `MCS_OFS_PATTERN)
      patternShadow_reg <= patMerged[PAT_W-1:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      multichannelEnable_reg <= 1'b0;
    else if (wrFire && awAddr_reg == `MCS_OFS_ENABLE)
      multichannelEnable_reg <= enMerged[0];
  end

  // Pending flag: a new request in the copy cycle is consumed by that copy
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pending_reg <= 1'b0;
    else if (!multichannelEnable_reg)
      pending_reg <= 1'b0;
    else if (copyNow)
      pending_reg <= 1'b0;
    else if (evt.trigHit)
      pending_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      activePattern_reg <= PAT_W'(`MCS_PAT_RESET);
    else if (copyNow)
      activePattern_reg <= patternShadow_reg;
  end

  // Timer shadow launches, one-cycle pulses
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mainXfer_reg <= 1'b0;
      auxXfer_reg <= 1'b0;
    end
    else
    begin
      mainXfer_reg <= pendingNow
        && ((ctrl_reg[`MCS_BIT_MAIN_UP] && mainPeriodUp)
        || (ctrl_reg[`MCS_BIT_MAIN_DN] && mainOneDown));
      auxXfer_reg <= pendingNow
        && ctrl_reg[`MCS_BIT_AUX_UP] && auxPeriodUp;
    end
  end

  // With enable set, outputs pass the PWM only while their pattern bit is one
  always_comb
  begin
    pwmOut_next = pwmIn;
    if (multichannelEnable_reg)
      for (int i = 0; i < PAT_W; i++)
        if (!activePattern_reg[i])
          pwmOut_next[i] = passiveLevel[i];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pwmOut_reg <= '0;
    else
      pwmOut_reg <= pwmOut_next;
  end

  // Read channel
  logic rdLoad;
  logic rdHit;
  assign s_axi_arready = !s_axi_rvalid;
  assign rdLoad = s_axi_arvalid && s_axi_arready;

  mcs_read_mux u_rd (
    .clk(clk),
    .reset_n(reset_n),
    .load(rdLoad),
    .addr(s_axi_araddr),
    .ctrlWord(ctrl_reg),
    .patternWord({15'h0000, pending_reg,
      {(8-PAT_W){1'b0}}, activePattern_reg,
      {(8-PAT_W){1'b0}}, patternShadow_reg}),
    .enableBit(multichannelEnable_reg),
    .data(s_axi_rdata),
    .hit(rdHit)
  );

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_axi_rvalid <= 1'b0;
    else if (rdLoad)
      s_axi_rvalid <= 1'b1;
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign s_axi_rresp = rdHit ? `MCS_RESP_OKAY : `MCS_RESP_SLVERR;
  assign pwmOut = pwmOut_reg;
  assign mainTimerShadowXfer = mainXfer_reg;
  assign auxTimerShadowXfer = auxXfer_reg;
  assign activePattern = activePattern_reg;
  assign transferPending = pending_reg;
endmodule : mcs_shadow_ctrl
`default_nettype wire

// >>> mcs_shadow_ctrl_properties.sv
/*
  Port checker for mcs_shadow_ctrl, bound to every instance of it.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module mcs_shadow_ctrl_properties #(
  parameter int PAT_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Write response
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Events
  input wire logic hallCorrect,
  input wire logic auxPeriodUp,
  input wire logic mainOneDown,
  input wire logic mainCompare1,
  input wire logic mainPeriodUp,
  input wire logic auxZero,
  input wire logic mainZeroUp,
  // PWM and status
  input wire logic [PAT_W-1:0] pwmIn,
  input wire logic [PAT_W-1:0] passiveLevel,
  input wire logic [PAT_W-1:0] pwmOut,
  input wire logic [PAT_W-1:0] activePattern,
  input wire logic mainTimerShadowXfer,
  input wire logic auxTimerShadowXfer,
  input wire logic transferPending
);
  logic anyTrig;
  logic anyEvt;
  assign anyTrig = hallCorrect | auxPeriodUp | mainOneDown | mainCompare1
    | mainPeriodUp;
  assign anyEvt = anyTrig | auxZero | mainZeroUp;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence bHeld;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence copyDone;
    !$stable(activePattern);
  endsequence
  a_pend_cause:
    assert property ($rose(transferPending) |-> $past(anyTrig))
    else $error("pending rose without trigger");
  // An enable write may also drop it, one or two cycles on
  a_pend_drop:
    assert property ($fell(transferPending) |-> $past(anyEvt)
      || $past(s_axi_bvalid) || s_axi_bvalid)
    else $error("pending dropped without cause");
  a_copy_cause:
    assert property (copyDone |-> $past(anyEvt) && !transferPending)
    else $error("pattern copied without event");
  a_main_xfer:
    assert property (mainTimerShadowXfer |-> $past(mainPeriodUp
      || mainOneDown) && $past(transferPending || anyTrig))
    else $error("main transfer without cause");
  a_aux_xfer:
    assert property (auxTimerShadowXfer |-> $past(auxPeriodUp)
      && $past(transferPending || anyTrig))
    else $error("aux transfer without cause");
  a_pass_pwm:
    assert property ($past(reset_n) |-> ($past(activePattern)
      & (pwmOut ^ $past(pwmIn))) == '0)
    else $error("enabled output not passing pwm");
  a_force_passive:
    assert property ($past(reset_n) |-> ((pwmOut ^ $past(pwmIn))
      & (pwmOut ^ $past(passiveLevel))) == '0)
    else $error("output neither pwm nor passive");
  a_bresp_held:
    assert property (bHeld |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule : mcs_shadow_ctrl_properties
bind mcs_shadow_ctrl mcs_shadow_ctrl_properties #(.PAT_W(PAT_W)) i_props (
  .clk, .reset_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .hallCorrect, .auxPeriodUp, .mainOneDown, .mainCompare1, .mainPeriodUp,
  .auxZero, .mainZeroUp, .pwmIn, .passiveLevel, .pwmOut, .activePattern,
  .mainTimerShadowXfer, .auxTimerShadowXfer, .transferPending);
`default_nettype wire

// >>> mcs_evt_model.sv
/*
  Far-side model: timers and hall comparator as event pulses.
  Assumes the bench asks for each burst with a one-cycle fireGo.
*/
`timescale 1ns/1ns
`default_nettype none
module mcs_evt_model (
  // Clock
  input wire logic clk,
  // Request
  input wire logic fireGo,
  input wire logic [6:0] fireMask,
  input wire logic [3:0] fireLag,
  // Event pulses
  output logic [6:0] pulse
);
  logic [6:0] heldMask = 7'h00;
  logic [4:0] waitCnt = 5'h00;
  initial pulse = 7'h00;
  // Timer events last one cycle only; plain always since the
  // variables also carry start values
  always @(posedge clk)
  begin
    pulse <= 7'h00;
    if (fireGo)
    begin
      heldMask <= fireMask;
      waitCnt <= {1'b0, fireLag} + 5'h01;
    end
    else if (waitCnt == 5'h01)
      pulse <= heldMask;
    if (!fireGo && waitCnt != 5'h00)
      waitCnt <= waitCnt - 5'h01;
  end
endmodule : mcs_evt_model
`default_nettype wire

// >>> mcs_shadow_ctrl_bench.sv
/*
  Bench for mcs_shadow_ctrl: bus tasks and event scenarios.
  Assumes the event model and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcs_cfg.svh"
module mcs_shadow_ctrl_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [5:0] pwmIn = 6'h3f;
  logic [5:0] passiveLevel = 6'h00;
  logic [5:0] pwmOut, activePattern;
  logic [5:0] expPat = 6'h00;
  logic mainTimerShadowXfer, auxTimerShadowXfer, transferPending;
  logic fireGo = 1'b0;
  logic [6:0] fireMask = 7'h00;
  logic [3:0] fireLag = 4'h0;
  logic [6:0] pulse;
  logic [2:0] seen = 3'h0;
  logic [6:0] xMask [4] = '{7'h10, 7'h04, 7'h02, 7'h16};
  logic [2:0] xExp [4] = '{3'h5, 3'h5, 3'h6, 3'h4};
  int mismatches = 0;
  int cmpCount = 0;
  always #4 clk = ~clk;
  always @(posedge clk)
    seen <= seen | {transferPending, auxTimerShadowXfer, mainTimerShadowXfer};
  mcs_evt_model i_model (.clk, .fireGo, .fireMask, .fireLag, .pulse);
  mcs_shadow_ctrl i_dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hallCorrect(pulse[0]),
    .auxPeriodUp(pulse[1]), .mainOneDown(pulse[2]),
    .mainCompare1(pulse[3]), .mainPeriodUp(pulse[4]), .auxZero(pulse[5]),
    .mainZeroUp(pulse[6]), .pwmIn, .passiveLevel, .pwmOut,
    .mainTimerShadowXfer, .auxTimerShadowXfer, .activePattern,
    .transferPending);
  task automatic completeRun;
    $display("%0d compares, %0d mismatches", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : completeRun
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic hang(input int n);
    if (n >= 40)
    begin
      mismatches++;
      completeRun();
    end
  endtask : hang
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 40);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang(n);
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 40);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang(n);
  endtask : axiRead
  // Lag plus pipeline leaves room for the slowest event
  task automatic fire(input logic [6:0] m);
    @(posedge clk);
    fireMask <= m;
    fireGo <= 1'b1;
    @(posedge clk);
    fireGo <= 1'b0;
    repeat (4 + fireLag) @(posedge clk);
    @(negedge clk);
  endtask : fire
  task automatic state(input logic [5:0] pat, input logic pend);
    check({25'h0, transferPending, activePattern}, {25'h0, pend, pat});
  endtask : state
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    axiRead(`MCS_OFS_SWCTRL);
    check(rd, 32'h0);
    axiWrite(`MCS_OFS_SWCTRL, 32'h0737);
    axiRead(`MCS_OFS_SWCTRL);
    check(rd, 32'h0737);
    axiWrite(8'h60, 32'h1);
    check(32'(rsp), 32'(`MCS_RESP_SLVERR));
    axiRead(8'h60);
    check(32'(rsp), 32'(`MCS_RESP_SLVERR));
    $display("register test done");
    axiWrite(`MCS_OFS_ENABLE, 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      axiWrite(`MCS_OFS_SWCTRL, 32'(16 + c));
      axiWrite(`MCS_OFS_PATTERN, 32'(c + 8));
      fire(c >= 1 && c <= 5 ? 7'h1f ^ 7'(1 << (c - 1)) : 7'h1f);
      state(expPat, 1'b0);
      if (c >= 1 && c <= 5)
      begin
        fire(7'(1 << (c - 1)));
        state(expPat, 1'b1);
        fire(7'h40);
        state(expPat, 1'b1);
        fire(7'h20);
        expPat = 6'(c + 8);
        state(expPat, 1'b0);
      end
    end
    $display("trigger test done");
    axiWrite(`MCS_OFS_SWCTRL, 32'h21);
    axiWrite(`MCS_OFS_PATTERN, 32'h2a);
    fire(7'h01);
    fire(7'h20);
    state(expPat, 1'b1);
    fire(7'h40);
    state(6'h2a, 1'b0);
    axiWrite(`MCS_OFS_SWCTRL, 32'h31);
    axiWrite(`MCS_OFS_PATTERN, 32'h0f);
    fire(7'h01);
    fire(7'h60);
    state(6'h2a, 1'b1);
    axiWrite(`MCS_OFS_ENABLE, 32'h0);
    fire(7'h01);
    state(6'h2a, 1'b0);
    axiWrite(`MCS_OFS_SWCTRL, 32'h01);
    axiWrite(`MCS_OFS_ENABLE, 32'h1);
    // Clear away from the rising edge so the sticky update cannot undo it
    @(negedge clk) seen = 3'h0;
    fire(7'h01);
    state(6'h0f, 1'b0);
    check(32'(seen[2]), 32'h0);
    check(32'(pwmOut), 32'h0f);
    axiRead(`MCS_OFS_PATTERN);
    check(rd, 32'h0f0f);
    $display("sync test done");
    axiWrite(`MCS_OFS_SWCTRL, 32'h0731);
    fire(7'h01);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        axiWrite(`MCS_OFS_SWCTRL, 32'h31);
      @(negedge clk) seen = 3'h0;
      fire(xMask[i]);
      check(32'(seen), 32'(xExp[i]));
    end
    // Slow partner: pending becomes set on the period match itself
    axiWrite(`MCS_OFS_ENABLE, 32'h0);
    axiWrite(`MCS_OFS_ENABLE, 32'h1);
    axiWrite(`MCS_OFS_SWCTRL, 32'h0135);
    fireLag = 4'h3;
    @(negedge clk) seen = 3'h0;
    fire(7'h10);
    check(32'(seen), 32'h5);
    $display("transfer test done");
    completeRun();
  end
endmodule : mcs_shadow_ctrl_bench
`default_nettype wire
